// File: rivm_top.sv
`timescale 1ns/100ps
// presents the fetch address for reset and for peripheral requests
module rivm_top
	import rivm_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               nrst_in,
	input  wire logic [3:0]         rst_cause_in,   // pin, power-on, brown-out, watchdog
	input  wire logic               boot_reset_fuse_in, // zero when programmed
	input  wire logic [PC_W-1:0]    boot_start_in,  // boot reset address
	input  wire logic [NUM_SRC-1:0] irq_in,         // request levels, held until served
	input  wire logic               irq_enable_in,  // core global interrupt enable
	input  wire logic               take_in,        // core loads the presented vector
	input  wire logic               ctrl_wr_in,     // core control register write
	input  wire logic [1:0]         ctrl_wdata_in,  // select, change-enable
	output logic [PC_W-1:0]         vector_out,     // fetch address
	output logic                    vector_valid_out,
	output logic                    vector_reset_out, // vector is the reset vector
	output logic [SRC_W-1:0]        vector_src_out, // source index of an irq vector
	output logic                    vector_table_select_out,
	output logic                    vector_change_enable_out,
	output logic                    irq_hold_out
);
	logic                 rst_s1;       // reset synchroniser, first stage
	logic                 rst_n;        // released reset for the rest
	logic                 found;        // a request is pending
	logic [SRC_W-1:0]     win;          // lowest pending source
	logic                 boot_pend;    // reset vector still owed after release
	logic                 next_boot_pend;
	rivm_state_t          state;
	rivm_state_t          next_state;
	logic [PC_W-1:0]      next_vector;
	logic                 next_valid;
	logic                 next_is_rst;
	logic [SRC_W-1:0]     next_src;
	logic [PC_W-1:0]      rst_addr;     // where reset goes now
	logic [PC_W-1:0]      tbl_base;     // offset added to the base table

	// release reset through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// request arbitration
	rivm_prio u_prio
	(
		.clk_in    (clk_in),
		.rst_n_in  (rst_n),
		.pend_in   (irq_in),
		.found_out (found),
		.idx_out   (win)
	);

	// control register select and change-enable sequence
	rivm_ctrl u_ctrl
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.wr_in    (ctrl_wr_in),
		.wdata_in (ctrl_wdata_in),
		.sel_out  (vector_table_select_out),
		.ce_out   (vector_change_enable_out),
		.hold_out (irq_hold_out)
	);

	// reset target follows the fuse only
	always_comb
	begin
		if (boot_reset_fuse_in == FUSE_PROG)
			rst_addr = boot_start_in;
		else
			rst_addr = RESET_VEC;
	end

	// table offset follows the select bit, independent of reset placement
	always_comb
	begin
		if (vector_table_select_out)
			tbl_base = boot_start_in;
		else
			tbl_base = '0;
	end

	// presentation sequence: reset beats any request, one vector at a time
	always_comb
	begin
		next_state     = state;
		next_vector    = vector_out;
		next_valid     = vector_valid_out;
		next_is_rst    = vector_reset_out;
		next_src       = vector_src_out;
		next_boot_pend = boot_pend;
		case (state)
			RIVM_IDLE:
			begin
				if (boot_pend || (|rst_cause_in))
				begin
					next_state     = RIVM_RST;
					next_vector    = rst_addr;
					next_valid     = 1'b1;
					next_is_rst    = 1'b1;
					next_src       = '0;
					next_boot_pend = 1'b0;
				end
				else if (found && irq_enable_in && !irq_hold_out)
				begin
					next_state  = RIVM_IRQ;
					next_vector = vec_addr(win, tbl_base);
					next_valid  = 1'b1;
					next_is_rst = 1'b0;
					next_src    = win;
				end
			end
			RIVM_RST:
			begin
				// a late cause simply re-presents the same reset vector
				next_vector = rst_addr;
				if (take_in)
				begin
					next_state = RIVM_IDLE;
					next_valid = 1'b0;
				end
			end
			RIVM_IRQ:
			begin
				if (|rst_cause_in)
				begin
					next_state  = RIVM_RST;
					next_vector = rst_addr;
					next_is_rst = 1'b1;
					next_src    = '0;
				end
				else if (take_in)
				begin
					next_state = RIVM_IDLE;
					next_valid = 1'b0;
				end
			end
			default:
			begin
				next_state = RIVM_IDLE;
				next_valid = 1'b0;
			end
		endcase
	end

	// register every output; boot_pend starts set so the core boots
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state            <= RIVM_IDLE;
			boot_pend        <= 1'b1;
			vector_out       <= '0;
			vector_valid_out <= 1'b0;
			vector_reset_out <= 1'b0;
			vector_src_out   <= '0;
		end
		else
		begin
			state            <= next_state;
			boot_pend        <= next_boot_pend;
			vector_out       <= next_vector;
			vector_valid_out <= next_valid;
			vector_reset_out <= next_is_rst;
			vector_src_out   <= next_src;
		end
	end

	// checks on the presented address
	default clocking dflt @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	logic irqv;   // interrupt vector on display with table at the start
	assign irqv = vector_valid_out && !vector_reset_out && !vector_table_select_out;

	sequence cause_seen;
		(|rst_cause_in) && (state != RIVM_RST);
	endsequence
	sequence rst_shown;
		vector_valid_out && vector_reset_out;
	endsequence

	reset_cause_a: assert property (cause_seen |-> ##[1:2] rst_shown)
		else $error("reset cause did not raise the reset vector");
	reset_place_a: assert property (vector_valid_out && vector_reset_out
		&& $stable(boot_reset_fuse_in)
		&& $stable(boot_start_in) |-> vector_out == ((boot_reset_fuse_in == FUSE_PROG)
		? boot_start_in : RESET_VEC))
		else $error("reset vector misplaced");
	irq_reloc_a: assert property (vector_valid_out && !vector_reset_out
		&& vector_table_select_out && $stable(boot_start_in)
		&& $stable(vector_table_select_out) |-> vector_out == boot_start_in
		+ TABLE_BASE + PC_W'({vector_src_out, 1'b0}))
		else $error("relocated vector wrong");
	slot_step_a: assert property (irqv && vector_src_out == 5'h1
		|-> vector_out == 17'h0_0004)
		else $error("slot spacing wrong");
	ext_map_a: assert property (irqv && vector_src_out == 5'h0 |-> vector_out == 17'h0_0002)
		else $error("external request 0 vector wrong");
	pcint_map_a: assert property (irqv && vector_src_out == 5'h6 |-> vector_out == 17'h0_000E)
		else $error("pin change 3 vector wrong");
	wdog_map_a: assert property (irqv && vector_src_out == 5'h7 |-> vector_out == 17'h0_0010)
		else $error("watchdog vector wrong");
	tmr2_map_a: assert property (irqv && vector_src_out == 5'ha |-> vector_out == 17'h0_0016)
		else $error("timer 2 overflow vector wrong");
	tmr1_map_a: assert property (irqv && vector_src_out == 5'hb |-> vector_out == 17'h0_0018)
		else $error("timer 1 capture vector wrong");
	tmr0_map_a: assert property (irqv && vector_src_out == 5'h11 |-> vector_out == 17'h0_0024)
		else $error("timer 0 overflow vector wrong");
	serial_map_a: assert property (irqv && vector_src_out == 5'h12 |-> vector_out == 17'h0_0026)
		else $error("serial transfer vector wrong");
	misc_map_a: assert property (irqv && vector_src_out == 5'h1a |-> vector_out == 17'h0_0036)
		else $error("program store vector wrong");
	usart2_map_a: assert property (irqv && vector_src_out == 5'h1d |-> vector_out == 17'h0_003C)
		else $error("second usart transmit vector wrong");
	rst_src_a: assert property (rst_shown |-> vector_src_out == 5'h0)
		else $error("reset vector carries a source index");

	// the remaining slots, one check each so a bad table entry is named by source

	// external requests
	ext2_map_a: assert property (irqv && vector_src_out == 5'h2
		|-> vector_out == 17'h0_0006)
		else $error("external request 2 vector wrong");

	// pin change requests 0..2; request 3 is checked above
	pin_change_request_0_map_a: assert property (irqv && vector_src_out == 5'h3
		|-> vector_out == 17'h0_0008)
		else $error("pin change 0 vector wrong");
	pcint1_map_a: assert property (irqv && vector_src_out == 5'h4
		|-> vector_out == 17'h0_000A)
		else $error("pin change 1 vector wrong");
	pcint2_map_a: assert property (irqv && vector_src_out == 5'h5
		|-> vector_out == 17'h0_000C)
		else $error("pin change 2 vector wrong");

	// timer 2 compare channels
	tmr2a_map_a: assert property (irqv && vector_src_out == 5'h8
		|-> vector_out == 17'h0_0012)
		else $error("timer 2 compare a vector wrong");
	tmr2b_map_a: assert property (irqv && vector_src_out == 5'h9
		|-> vector_out == 17'h0_0014)
		else $error("timer 2 compare b vector wrong");

	// timer 1 compare channels and overflow
	tmr1a_map_a: assert property (irqv && vector_src_out == 5'hc
		|-> vector_out == 17'h0_001A)
		else $error("timer 1 compare a vector wrong");
	tmr1b_map_a: assert property (irqv && vector_src_out == 5'hd
		|-> vector_out == 17'h0_001C)
		else $error("timer 1 compare b vector wrong");
	tmr1o_map_a: assert property (irqv && vector_src_out == 5'he
		|-> vector_out == 17'h0_001E)
		else $error("timer 1 overflow vector wrong");

	// timer 0 compare channels
	tmr0a_map_a: assert property (irqv && vector_src_out == 5'hf
		|-> vector_out == 17'h0_0020)
		else $error("timer 0 compare a vector wrong");
	tmr0b_map_a: assert property (irqv && vector_src_out == 5'h10
		|-> vector_out == 17'h0_0022)
		else $error("timer 0 compare b vector wrong");

	// first usart
	usart_rx_a: assert property (irqv && vector_src_out == 5'h13
		|-> vector_out == 17'h0_0028)
		else $error("first usart receive vector wrong");
	usart_empty_a: assert property (irqv && vector_src_out == 5'h14
		|-> vector_out == 17'h0_002A)
		else $error("first usart empty vector wrong");
	usart_tx_a: assert property (irqv && vector_src_out == 5'h15
		|-> vector_out == 17'h0_002C)
		else $error("first usart transmit vector wrong");

	// comparator, conversion, data memory and two-wire slots
	comp_map_a: assert property (irqv && vector_src_out == 5'h16
		|-> vector_out == 17'h0_002E)
		else $error("analog comparator vector wrong");
	conv_map_a: assert property (irqv && vector_src_out == 5'h17
		|-> vector_out == 17'h0_0030)
		else $error("conversion complete vector wrong");
	nvm_map_a: assert property (irqv && vector_src_out == 5'h18
		|-> vector_out == 17'h0_0032)
		else $error("data memory ready vector wrong");
	twowire_map_a: assert property (irqv && vector_src_out == 5'h19
		|-> vector_out == 17'h0_0034)
		else $error("two wire done vector wrong");

	// second usart receive and empty
	usart2_rx_a: assert property (irqv && vector_src_out == 5'h1b
		|-> vector_out == 17'h0_0038)
		else $error("second usart receive vector wrong");
	usart2_empty_a: assert property (irqv && vector_src_out == 5'h1c
		|-> vector_out == 17'h0_003A)
		else $error("second usart empty vector wrong");

	hold_block_a: assert property (irq_hold_out && state == RIVM_IDLE && !boot_pend
		&& !(|rst_cause_in) |=> !vector_valid_out)
		else $error("interrupt presented while held off");
endmodule // rivm_top

// File: rivm_pkg.sv
// Summary of operation
// - each vector slot spans two program words
// - reset vector zero, or boot address if fused
// - select bit adds boot start to interrupt vectors
// - table starts 0x0002 or boot plus 0x0002
// - four reset causes all take reset vector
// - external requests 0..2 at 0x0002..0x0006
// - pin-change requests 0..3 at 0x0008..0x000E
// - watchdog time-out request at 0x0010
// - timer 2 requests at 0x0012..0x0016
// - timer 1 requests at 0x0018..0x001E
// - timer 0 requests at 0x0020..0x0024
// - serial, first usart at 0x0026..0x002C
// - five misc requests at 0x002E..0x0036
// - second usart requests at 0x0038..0x003C
// - enable self-clears, interrupts held off meanwhile
package rivm_pkg;
	localparam int                PC_W         = 17;            // program word address width
	localparam int                NUM_SRC      = 30;            // peripheral request lines
	localparam int                SRC_W        = 5;             // width of a source index
	localparam logic [PC_W-1:0]   RESET_VEC    = 17'h0_0000;    // reset vector, fuse unprogrammed
	localparam logic [PC_W-1:0]   TABLE_BASE   = 17'h0_0002;    // first interrupt slot
	localparam int                VEC_SPACING  = 2;             // words per slot
	localparam logic [2:0]        CHANGE_CYC   = 3'h3;          // enable lives this plus one cycles
	localparam logic              FUSE_PROG    = 1'h0;          // fuse reads zero when programmed
	localparam int                CTRL_SEL_BIT = 1;             // select bit in control write data
	localparam int                CTRL_CE_BIT  = 0;             // change-enable bit in write data

	// presentation states, gray along idle -> reset -> irq
	typedef enum logic [1:0]
	{
		RIVM_IDLE = 2'h0,
		RIVM_RST  = 2'h1,
		RIVM_IRQ  = 2'h3
	} rivm_state_t;

	// word address of a source's slot; base is zero or the boot start
	function automatic logic [PC_W-1:0] vec_addr(input logic [SRC_W-1:0] src,
		input logic [PC_W-1:0] base);
		vec_addr = base + TABLE_BASE + PC_W'(src) * PC_W'(VEC_SPACING);
	endfunction
endpackage

// File: rivm_prio.sv
`timescale 1ns/100ps
// picks the lowest-numbered pending request, registered
module rivm_prio
	import rivm_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic [NUM_SRC-1:0] pend_in,
	output logic                    found_out,
	output logic [SRC_W-1:0]        idx_out
);
	logic             next_found;  // any request pending
	logic [SRC_W-1:0] next_idx;    // winning source

	// scan from the top so the lowest index is written last and wins
	always_comb
	begin
		next_found = 1'b0;
		next_idx   = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pend_in[i])
			begin
				next_found = 1'b1;
				next_idx   = SRC_W'(i);
			end
		end
	end

	// register the choice; costs one cycle but keeps the adder path short
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			found_out <= 1'b0;
			idx_out   <= '0;
		end
		else
		begin
			found_out <= next_found;
			idx_out   <= next_idx;
		end
	end

	logic [NUM_SRC-1:0] pend_d; // helper copy for the check below
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pend_d <= '0;
		else
			pend_d <= pend_in;
	end

	prio_lowest_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		found_out |-> pend_d[idx_out] && ((pend_d & ((NUM_SRC'(1) << idx_out) - 1'b1)) == '0))
		else $error("served source is not the lowest pending");
endmodule // rivm_prio

// File: rivm_ctrl.sv
`timescale 1ns/100ps
// timed change sequence for the vector table select bit
module rivm_ctrl
	import rivm_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       wr_in,      // core writes the control register
	input  wire logic [1:0] wdata_in,   // select and change-enable bits
	output logic            sel_out,    // vector_table_select
	output logic            ce_out,     // vector_change_enable
	output logic            hold_out    // interrupts held off
);
	logic [2:0] cnt;        // cycles left for the enable
	logic [2:0] next_cnt;
	logic       next_sel;
	logic       next_ce;
	logic       next_hold;
	logic       wr_ce;      // write that sets change-enable
	logic       wr_sel;     // write that commits the select bit

	assign wr_ce  = wr_in && wdata_in[CTRL_CE_BIT];
	assign wr_sel = wr_in && !wdata_in[CTRL_CE_BIT] && ce_out;

	// sequence: enable opens a short window, a write with enable low commits
	always_comb
	begin
		next_sel  = sel_out;
		next_ce   = ce_out;
		next_cnt  = cnt;
		next_hold = 1'b0;
		if (wr_ce)
		begin
			next_ce   = 1'b1;          // rewrite restarts the window
			next_cnt  = CHANGE_CYC;
			next_hold = 1'b1;
		end
		else if (wr_sel)
		begin
			next_sel  = wdata_in[CTRL_SEL_BIT];
			next_ce   = 1'b0;
			next_hold = 1'b1;          // covers the instruction after the write
		end
		else if (ce_out)
		begin
			next_hold = 1'b1;
			if (cnt == '0)
			begin
				next_ce   = 1'b0;
				next_hold = 1'b0;
			end
			else
				next_cnt = cnt - 3'h1;
		end
	end

	// writes without the enable leave the select bit alone: that is the guard
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sel_out  <= 1'b0;
			ce_out   <= 1'b0;
			cnt      <= '0;
			hold_out <= 1'b0;
		end
		else
		begin
			sel_out  <= next_sel;
			ce_out   <= next_ce;
			cnt      <= next_cnt;
			hold_out <= next_hold;
		end
	end

	ce_expire_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		($rose(ce_out) && !wr_in) ##1 (!wr_in [*3]) |=> !ce_out)
		else $error("change enable outlived its window");
	ce_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_out |-> hold_out)
		else $error("interrupts not held while change enabled");
	sel_guard_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!ce_out |=> sel_out == $past(sel_out))
		else $error("select changed without enable");
	sel_commit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_sel |=> !ce_out && sel_out == $past(wdata_in[CTRL_SEL_BIT]))
		else $error("select write not committed");
endmodule // rivm_ctrl

// File: rivm_core_model.sv
`timescale 1ns/100ps
// fetch side of the core: loads a shown vector after a short or a long wait
module rivm_core_model
	import rivm_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             slow_in,     // wait six cycles instead of two
	input  wire logic             valid_in,    // a vector is shown
	input  wire logic [PC_W-1:0]  vector_in,
	input  wire logic             reset_in,
	input  wire logic [SRC_W-1:0] src_in,
	output logic                  take_out,    // one-cycle load pulse
	output logic [PC_W-1:0]       got_vec_out, // last vector loaded
	output logic                  got_rst_out,
	output logic [SRC_W-1:0]      got_src_out,
	output int                    got_cnt_out  // loads so far
);
	logic [2:0] wait_cnt; // cycles the vector has stood so far

	initial
	begin
		take_out = 1'b0;
		wait_cnt = 3'h0;
		got_vec_out = '0;
		got_rst_out = 1'b0;
		got_src_out = '0;
		got_cnt_out = 0;
	end

	// valid is still high at the edge that samples the take, so the pulse
	// is dropped there; a second take would load a vector never shown
	always @(posedge clk_in)
	begin
		if (valid_in && take_out)
		begin
			got_vec_out <= vector_in;
			got_rst_out <= reset_in;
			got_src_out <= src_in;
			got_cnt_out <= got_cnt_out + 1;
			take_out <= 1'b0;
			wait_cnt <= 3'h0;
		end
		else if (valid_in)
		begin
			if (wait_cnt >= (slow_in ? 3'h5 : 3'h1))
				take_out <= 1'b1;
			else
				wait_cnt <= wait_cnt + 3'h1;
		end
		else
		begin
			take_out <= 1'b0;
			wait_cnt <= 3'h0;
		end
	end
endmodule // rivm_core_model

// File: tb_top.sv
`timescale 1ns/100ps
// bench for the vector map: reset, every slot, priority, select sequence
module tb_top
	import rivm_pkg::*;
;
	logic               clk;
	logic               nrst;
	logic [3:0]         rst_cause;
	logic               fuse;       // zero when programmed
	logic [PC_W-1:0]    boot_start;
	logic [NUM_SRC-1:0] irq_pend;   // peripheral request flags
	logic               irq_en;
	logic               take;
	logic               ctrl_wr;
	logic [1:0]         ctrl_wdata;
	logic               slow;
	logic [PC_W-1:0]    vector;
	logic               vector_valid;
	logic               vector_reset;
	logic [SRC_W-1:0]   vector_src;
	logic               sel;
	logic               ce;
	logic               hold;
	logic [PC_W-1:0]    got_vec;
	logic               got_rst;
	logic [SRC_W-1:0]   got_src;
	int                 got_cnt;
	int                 err_count = 0;
	int                 n_checks = 0;
	localparam logic [PC_W-1:0] BOOT = 17'h1_F000; // boot reset address used

	rivm_top rivm_top_inst (.clk_in(clk), .nrst_in(nrst), .rst_cause_in(rst_cause),
		.boot_reset_fuse_in(fuse), .boot_start_in(boot_start), .irq_in(irq_pend),
		.irq_enable_in(irq_en), .take_in(take), .ctrl_wr_in(ctrl_wr),
		.ctrl_wdata_in(ctrl_wdata), .vector_out(vector), .vector_valid_out(vector_valid),
		.vector_reset_out(vector_reset), .vector_src_out(vector_src),
		.vector_table_select_out(sel), .vector_change_enable_out(ce),
		.irq_hold_out(hold));

	rivm_core_model rivm_core_model_inst (.clk_in(clk), .slow_in(slow),
		.valid_in(vector_valid), .vector_in(vector), .reset_in(vector_reset),
		.src_in(vector_src), .take_out(take), .got_vec_out(got_vec),
		.got_rst_out(got_rst), .got_src_out(got_src), .got_cnt_out(got_cnt));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// a peripheral drops its flag once its vector is shown, well before the take
	always @(posedge clk)
		if (vector_valid && !vector_reset)
			irq_pend[vector_src] <= 1'b0;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [PC_W-1:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// own slot arithmetic: base plus two words per vector number
	function automatic logic [PC_W-1:0] slot(input int i, input logic [PC_W-1:0] base);
		slot = base + 17'h0_0002 + PC_W'(2 * i);
	endfunction

	// waits, bounded, for the core to load one vector and judges it
	task automatic wait_take(input logic [PC_W-1:0] ev, input logic er, input int es);
		int start;
		int i;
		start = got_cnt;
		for (i = 0; i < 60 && got_cnt == start; i++)
			@(negedge clk);
		check("load count", PC_W'(start + 1), PC_W'(got_cnt));
		check("vector", ev, got_vec);
		check("reset flag", PC_W'(er), PC_W'(got_rst));
		check("source", PC_W'(es), PC_W'(got_src));
	endtask

	task automatic do_reset(input logic f, input logic [PC_W-1:0] ev);
		@(posedge clk);
		nrst <= 1'b0;
		fuse <= f;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wait_take(ev, 1'b1, 0);
	endtask

	task automatic ctrl_write(input logic [1:0] d);
		@(posedge clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= d;
		@(posedge clk);
		ctrl_wr <= 1'b0;
	endtask

	task automatic t_map();
		for (int i = 0; i < NUM_SRC; i++)
		begin
			@(posedge clk);
			slow <= i[0];
			irq_pend[i] <= 1'b1;
			wait_take(slot(i, '0), 1'b0, i);
		end
	endtask

	task automatic t_cause();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			rst_cause <= 4'h1 << k;
			@(posedge clk);
			rst_cause <= 4'h0;
			wait_take(BOOT, 1'b1, 0);
		end
	endtask

	// two pending at once, the lower number must go first
	task automatic t_prio();
		@(posedge clk);
		slow <= 1'b1;
		irq_pend[29] <= 1'b1;
		irq_pend[4] <= 1'b1;
		wait_take(slot(4, '0), 1'b0, 4);
		wait_take(slot(29, '0), 1'b0, 29);
	endtask

	task automatic t_refuse();
		int start;
		start = got_cnt;
		@(posedge clk);
		irq_en <= 1'b0;
		irq_pend[8] <= 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		check("disabled loads", PC_W'(start), PC_W'(got_cnt));
		@(posedge clk);
		irq_en <= 1'b1;
		wait_take(slot(8, '0), 1'b0, 8);
	endtask

	// timed select change; a request waits out the hold, then lands in boot space
	task automatic t_select();
		ctrl_write(2'b01);
		@(negedge clk);
		check("enable set", PC_W'(1), PC_W'(ce));
		check("hold set", PC_W'(1), PC_W'(hold));
		@(posedge clk);
		irq_pend[0] <= 1'b1;
		ctrl_write(2'b10);
		@(negedge clk);
		check("select", PC_W'(1), PC_W'(sel));
		check("enable cleared", PC_W'(0), PC_W'(ce));
		check("held vector", PC_W'(0), PC_W'(vector_valid));
		wait_take(slot(0, BOOT), 1'b0, 0);
		ctrl_write(2'b01);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("enable alive", PC_W'(1), PC_W'(ce));
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("enable timeout", PC_W'(0), PC_W'(ce));
		check("hold timeout", PC_W'(0), PC_W'(hold));
		ctrl_write(2'b00);
		@(negedge clk);
		check("select kept", PC_W'(1), PC_W'(sel));
		@(posedge clk);
		irq_pend[29] <= 1'b1;
		wait_take(slot(29, BOOT), 1'b0, 29);
	endtask

	initial
	begin
		nrst = 1'b0;
		rst_cause = 4'h0;
		fuse = 1'b1;
		boot_start = BOOT;
		irq_pend = '0;
		irq_en = 1'b1;
		ctrl_wr = 1'b0;
		ctrl_wdata = 2'h0;
		slow = 1'b0;
		do_reset(1'b1, 17'h0_0000);
		do_reset(1'b0, BOOT);
		t_map();
		t_cause();
		t_prio();
		t_refuse();
		t_select();
		finish_test();
	end

	// cuts a hang short, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule // tb_top
